// ### logic/lspc_params.svh
// Constants of the shared pin control block: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the block's design files.
// What this block does
// - Parallel host mode: five shared pins form the register address from the host.
// - Hardware mode: low termination-mode pin selects internal, high selects external termination.
// - Hardware mode: four monitor select pins route one channel 2-8 to receiver 1.
// - Output enable pin low puts every transmitter tip and ring in high impedance.
// - With the pin-control bit set, output enable low also drops all receive termination.
// - Edge select high: serial data out valid on falling edge; low: rising edge.
// - Edge select high inverts every receive clock, overriding the per-channel inversion register.
// - Edge select low: each channel's receive clock follows its inversion register bit.
// - Hardware mode: termination-off pin high switches off all receive termination.
`ifndef LSPC_PARAMS_SVH
`define LSPC_PARAMS_SVH

// Register byte offsets
`define LSPC_OFS_CTRL 8'h00
`define LSPC_OFS_RXINV 8'h04
`define LSPC_OFS_STATUS 8'h08
`define LSPC_OFS_ROUTE 8'h0c

// Control register fields
`define LSPC_CTRL_MODE_LSB 0
`define LSPC_CTRL_MODE_MSB 1
`define LSPC_CTRL_TERM_PIN_BIT 2

// Status register fields
`define LSPC_STAT_ADDR_LSB 0
`define LSPC_STAT_OE_BIT 5
`define LSPC_STAT_EDGE_BIT 6
`define LSPC_STAT_TOFF_BIT 7
`define LSPC_STAT_TMODE_BIT 8
`define LSPC_STAT_VIOL_BIT 9

// Reset values
`define LSPC_CTRL_RESET 3'h3
`define LSPC_RXINV_RESET 8'h00

`endif

// ### logic/lspc_pkg.sv
// Types shared by the shared pin control block.
// Assumes nothing of its surroundings.
package lspc_pkg;

    // Host interface mode selected by software
    typedef enum logic [1:0] {
        LSPC_MODE_PARALLEL,
        LSPC_MODE_SERIAL,
        LSPC_MODE_MUXED,
        LSPC_MODE_HARDWARE
    } lspc_host_mode_t;

    // AHB bus-cycle state of the slave
    typedef enum logic {
        LSPC_BUS_IDLE,
        LSPC_BUS_DATA
    } lspc_bus_state_t;

endpackage : lspc_pkg

// ### logic/lspc_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes inputs are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/1ps
module lspc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_r;

    // Two flip-flops in series, nothing reads the first
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule : lspc_sync

// ### logic/lspc_pin_control.sv
// Shared control pin interpreter of an octal line interface, with an AHB-Lite register slave.
// Assumes pins arrive asynchronously to hclk; one AHB-Lite master, single word transfers.
`timescale 1ns/1ps
`include "lspc_params.svh"
module lspc_pin_control #(
    parameter int CHANNELS = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [4:0] shared_addr_pins,
    input wire logic output_enable_pin,
    input wire logic serial_edge_select,
    input wire logic rx_termination_off,
    output logic [4:0] host_reg_addr,
    output logic host_addr_valid,
    output logic rx_term_external,
    output logic monitor_active,
    output logic monitor_is_tx,
    output logic [3:0] monitor_channel,
    output logic [CHANNELS-1:0] tx_line_hiz,
    output logic [CHANNELS-1:0] rx_term_disable,
    output logic serial_out_fall_edge,
    output logic [CHANNELS-1:0] rx_clk_invert
);
    logic [4:0] addr_s;
    logic oe_s;
    logic edge_s;
    logic toff_s;
    lspc_pkg::lspc_host_mode_t mode_r;
    logic term_pin_ctl_r;
    logic [CHANNELS-1:0] rx_clock_invert_reg_r;
    logic viol_r;
    lspc_pkg::lspc_bus_state_t bus_r;
    logic [7:0] addr_r;
    logic write_r;
    logic hw_mode;
    logic [5:0] route_lut;
    logic wr_en;
    logic viol_clr;
    logic [31:0] rd_value;

    // Pin levels are brought onto hclk before any use
    lspc_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .async_in({rx_termination_off, serial_edge_select, output_enable_pin, shared_addr_pins}),
        .sync_out({toff_s, edge_s, oe_s, addr_s})
    );

    assign hw_mode = (mode_r == lspc_pkg::LSPC_MODE_HARDWARE);

    // Monitor code lookup: {active, is_tx, channel}
    function automatic logic [5:0] monitor_lut(input logic [3:0] code);
        logic [5:0] res;
        res = 6'h00;
        case (code)
            4'h1: res = 6'h22;
            4'h2: res = 6'h23;
            4'h3: res = 6'h24;
            4'h4: res = 6'h25;
            4'h5: res = 6'h26;
            4'h6: res = 6'h27;
            4'h7: res = 6'h28;
            4'h9: res = 6'h32;
            4'ha: res = 6'h33;
            4'hb: res = 6'h34;
            4'hc: res = 6'h35;
            4'hd: res = 6'h36;
            4'he: res = 6'h37;
            4'hf: res = 6'h38;
            default: res = 6'h00;
        endcase
        return res;
    endfunction : monitor_lut

    assign route_lut = monitor_lut(addr_s[3:0]);

    // AHB-Lite slave: one address phase, two-cycle data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_r <= lspc_pkg::LSPC_BUS_IDLE;
            addr_r <= 8'h00;
            write_r <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
        end
        else
        begin
            case (bus_r)
                lspc_pkg::LSPC_BUS_IDLE:
                begin
                    if (hsel && htrans[1] && hready)
                    begin
                        bus_r <= lspc_pkg::LSPC_BUS_DATA;
                        addr_r <= haddr;
                        write_r <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                lspc_pkg::LSPC_BUS_DATA:
                begin
                    bus_r <= lspc_pkg::LSPC_BUS_IDLE;
                    hreadyout <= 1'b1;
                    hrdata <= write_r ? 32'h00000000 : rd_value;
                end
                default:
                begin
                    bus_r <= lspc_pkg::LSPC_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Response is always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    assign wr_en = (bus_r == lspc_pkg::LSPC_BUS_DATA) && write_r;
    assign viol_clr = wr_en && (addr_r == `LSPC_OFS_STATUS) && hwdata[`LSPC_STAT_VIOL_BIT];

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        rd_value = 32'h00000000;
        case (addr_r)
            `LSPC_OFS_CTRL:
            begin
                rd_value[`LSPC_CTRL_MODE_MSB:`LSPC_CTRL_MODE_LSB] = mode_r;
                rd_value[`LSPC_CTRL_TERM_PIN_BIT] = term_pin_ctl_r;
            end
            `LSPC_OFS_RXINV: rd_value[CHANNELS-1:0] = rx_clock_invert_reg_r;
            `LSPC_OFS_STATUS:
            begin
                rd_value[`LSPC_STAT_ADDR_LSB+4:`LSPC_STAT_ADDR_LSB] = addr_s;
                rd_value[`LSPC_STAT_OE_BIT] = oe_s;
                rd_value[`LSPC_STAT_EDGE_BIT] = edge_s;
                rd_value[`LSPC_STAT_TOFF_BIT] = toff_s;
                rd_value[`LSPC_STAT_TMODE_BIT] = rx_term_external;
                rd_value[`LSPC_STAT_VIOL_BIT] = viol_r;
            end
            `LSPC_OFS_ROUTE:
                rd_value[5:0] = {monitor_active, monitor_is_tx, monitor_channel};
            default: rd_value = 32'h00000000;
        endcase
    end

    // Software control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_r <= lspc_pkg::lspc_host_mode_t'(2'(`LSPC_CTRL_RESET));
            term_pin_ctl_r <= 1'(`LSPC_CTRL_RESET >> `LSPC_CTRL_TERM_PIN_BIT);
            rx_clock_invert_reg_r <= CHANNELS'(`LSPC_RXINV_RESET);
        end
        else if (wr_en)
        begin
            if (addr_r == `LSPC_OFS_CTRL)
            begin
                mode_r <= lspc_pkg::lspc_host_mode_t'(
                    hwdata[`LSPC_CTRL_MODE_MSB:`LSPC_CTRL_MODE_LSB]);
                term_pin_ctl_r <= hwdata[`LSPC_CTRL_TERM_PIN_BIT];
            end
            if (addr_r == `LSPC_OFS_RXINV)
                rx_clock_invert_reg_r <= hwdata[CHANNELS-1:0];
        end
    end

    // Sticky flag: shared pins not low in serial or multiplexed mode; set beats clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            viol_r <= 1'b0;
        else if ((mode_r == lspc_pkg::LSPC_MODE_SERIAL || mode_r == lspc_pkg::LSPC_MODE_MUXED)
                 && (addr_s != 5'h00))
            viol_r <= 1'b1;
        else if (viol_clr)
            viol_r <= 1'b0;
    end

    // Register address from the shared pins in parallel host mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            host_reg_addr <= 5'h00;
            host_addr_valid <= 1'b0;
        end
        else
        begin
            host_addr_valid <= (mode_r == lspc_pkg::LSPC_MODE_PARALLEL);
            host_reg_addr <= (mode_r == lspc_pkg::LSPC_MODE_PARALLEL) ? addr_s : 5'h00;
        end
    end

    // Hardware mode termination choice and monitor routing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_term_external <= 1'b0;
            monitor_active <= 1'b0;
            monitor_is_tx <= 1'b0;
            monitor_channel <= 4'h0;
        end
        else
        begin
            rx_term_external <= hw_mode && addr_s[4];
            monitor_active <= hw_mode && route_lut[5];
            monitor_is_tx <= hw_mode && route_lut[4];
            monitor_channel <= hw_mode ? route_lut[3:0] : 4'h0;
        end
    end

    // Line transmitter and receive termination controls
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_line_hiz <= '1;
            rx_term_disable <= '0;
        end
        else
        begin
            tx_line_hiz <= {CHANNELS{!oe_s}};
            rx_term_disable <= {CHANNELS{(!oe_s && term_pin_ctl_r)
                                         || (hw_mode && toff_s)}};
        end
    end

    // Clock edge selection for serial output and receive clocks
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            serial_out_fall_edge <= 1'b0;
            rx_clk_invert <= '0;
        end
        else
        begin
            serial_out_fall_edge <= edge_s;
            rx_clk_invert <= edge_s ? {CHANNELS{1'b1}}
                                    : rx_clock_invert_reg_r;
        end
    end
endmodule : lspc_pin_control

// ### tb/lspc_pin_control_monitor.sv
// Port checker of the shared pin control block.
// Assumes it is bound to every instance of the block.
`timescale 1ns/1ps
module lspc_pin_control_monitor #(
    parameter int CHANNELS = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [4:0] shared_addr_pins,
    input wire logic output_enable_pin,
    input wire logic serial_edge_select,
    input wire logic [4:0] host_reg_addr,
    input wire logic host_addr_valid,
    input wire logic monitor_active,
    input wire logic [3:0] monitor_channel,
    input wire logic [CHANNELS-1:0] tx_line_hiz,
    input wire logic serial_out_fall_edge,
    input wire logic [CHANNELS-1:0] rx_clk_invert
);
    // All checks run on the bus clock
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_oe_hiz: assert property (!output_enable_pin [*4] |=> &tx_line_hiz)
        else $error("transmitters driven while output enable low");
    a_oe_drive: assert property (output_enable_pin [*4] |=> tx_line_hiz == '0)
        else $error("transmitters off while output enable high");
    a_edge_high: assert property (serial_edge_select [*4] |=>
        serial_out_fall_edge && &rx_clk_invert)
        else $error("edge select high not applied");
    a_edge_low: assert property (!serial_edge_select [*4] |=> !serial_out_fall_edge)
        else $error("falling edge chosen with edge select low");
    a_addr_follow: assert property ((host_addr_valid && $stable(shared_addr_pins)) [*4]
        |=> !host_addr_valid || host_reg_addr == $past(shared_addr_pins))
        else $error("register address does not follow pins");
    a_mode_gate: assert property (host_addr_valid ? !monitor_active
        : host_reg_addr == 5'h00)
        else $error("address or monitor output disagrees with host mode");
    a_bus_answer: assert property (hsel && htrans[1] && hready && hreadyout
        |=> !hreadyout ##1 hreadyout && !hresp)
        else $error("bus answer timing wrong");
    a_mon_range: assert property ((monitor_active && monitor_channel inside {[4'h2:4'h8]})
        || (!monitor_active && monitor_channel == 4'h0))
        else $error("monitored channel out of range");
endmodule : lspc_pin_control_monitor

bind lspc_pin_control lspc_pin_control_monitor #(.CHANNELS(CHANNELS)) mon_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .shared_addr_pins(shared_addr_pins),
    .output_enable_pin(output_enable_pin), .serial_edge_select(serial_edge_select),
    .host_reg_addr(host_reg_addr), .host_addr_valid(host_addr_valid),
    .monitor_active(monitor_active), .monitor_channel(monitor_channel),
    .tx_line_hiz(tx_line_hiz), .serial_out_fall_edge(serial_out_fall_edge),
    .rx_clk_invert(rx_clk_invert)
);

// ### tb/lspc_strap_model.sv
// Host-side strapping of the shared address pins.
// Assumes the bench tells it the host mode it has programmed.
`timescale 1ns/1ps
module lspc_strap_model (
    input wire logic hclk,
    input wire logic [1:0] host_mode,
    input wire logic [4:0] pin_req,
    output logic [4:0] shared_addr_pins
);
    // Ground the pins in serial and multiplexed modes
    always_ff @(posedge hclk)
    begin
        if (host_mode inside {lspc_pkg::LSPC_MODE_SERIAL, lspc_pkg::LSPC_MODE_MUXED})
            shared_addr_pins <= 5'h00;
        else
            shared_addr_pins <= pin_req;
    end
endmodule : lspc_strap_model

// ### tb/tb_lspc_pin_control.sv
// Self-checking bench of the shared pin control block.
// Assumes the strap model and the bound port checker are compiled first.
`timescale 1ns/1ps
`include "lspc_params.svh"
module tb_lspc_pin_control;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, host_addr_valid, rx_term_external;
    logic monitor_active, monitor_is_tx, serial_out_fall_edge;
    logic [1:0] host_mode = 2'h3;
    logic [4:0] pin_req = 5'h00;
    logic [4:0] shared_addr_pins, host_reg_addr;
    logic oe_pin = 1'b1;
    logic edge_pin = 1'b0;
    logic toff_pin = 1'b0;
    logic [3:0] monitor_channel;
    logic [7:0] tx_line_hiz, rx_term_disable, rx_clk_invert;
    int errors = 0;
    int total_checks = 0;

    lspc_strap_model lspc_strap_model_i (.hclk(hclk), .host_mode(host_mode),
        .pin_req(pin_req), .shared_addr_pins(shared_addr_pins));

    lspc_pin_control lspc_pin_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .shared_addr_pins(shared_addr_pins), .output_enable_pin(oe_pin),
        .serial_edge_select(edge_pin), .rx_termination_off(toff_pin),
        .host_reg_addr(host_reg_addr), .host_addr_valid(host_addr_valid),
        .rx_term_external(rx_term_external), .monitor_active(monitor_active),
        .monitor_is_tx(monitor_is_tx), .monitor_channel(monitor_channel),
        .tx_line_hiz(tx_line_hiz), .rx_term_disable(rx_term_disable),
        .serial_out_fall_edge(serial_out_fall_edge), .rx_clk_invert(rx_clk_invert));

    // Free-running bus clock
    initial
    begin
        forever #2.5 hclk = ~hclk;
    end

    task automatic close_out;
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // One single-word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready_s() !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready_s() !== 1'b1);
        r = hrdata;
    endtask : xfer

    function automatic logic hready_s();
        return hreadyout;
    endfunction : hready_s

    task automatic settle;
        repeat (6) @(posedge hclk);
    endtask : settle

    task automatic t_regs;
        xfer(1'b0, `LSPC_OFS_CTRL, 32'h0, q);
        chk("ctrl", 32'h3, q);
        xfer(1'b0, `LSPC_OFS_RXINV, 32'h0, q);
        chk("rxinv", 32'h0, q);
        xfer(1'b1, 8'h10, 32'hffff_ffff, q);
        xfer(1'b0, 8'h10, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask : t_regs

    task automatic t_monitor;
        for (int c = 0; c < 16; c++)
        begin
            pin_req <= {c[0], c[3:0]};
            settle();
            chk("mon_on", 32'((c % 8) != 0), monitor_active);
            chk("mon_ch", (c % 8) == 0 ? 32'h0 : 32'(c % 8 + 1), monitor_channel);
            chk("mon_tx", 32'(c > 8), monitor_is_tx);
            chk("term_ext", 32'(c[0]), rx_term_external);
        end
    endtask : t_monitor

    task automatic t_oe;
        oe_pin <= 1'b0;
        settle();
        chk("hiz", 32'hff, tx_line_hiz);
        chk("tdis_off", 32'h0, rx_term_disable);
        xfer(1'b1, `LSPC_OFS_CTRL, 32'h7, q);
        settle();
        chk("tdis_on", 32'hff, rx_term_disable);
        oe_pin <= 1'b1;
        settle();
        chk("hiz_off", 32'h0, tx_line_hiz);
        toff_pin <= 1'b1;
        settle();
        chk("toff_hw", 32'hff, rx_term_disable);
    endtask : t_oe

    task automatic t_edge;
        xfer(1'b1, `LSPC_OFS_RXINV, 32'ha5, q);
        settle();
        chk("inv_reg", 32'ha5, rx_clk_invert);
        chk("rise", 32'h0, serial_out_fall_edge);
        edge_pin <= 1'b1;
        settle();
        chk("inv_all", 32'hff, rx_clk_invert);
        chk("fall", 32'h1, serial_out_fall_edge);
    endtask : t_edge

    task automatic t_parallel;
        host_mode <= 2'h0;
        pin_req <= 5'h13;
        xfer(1'b1, `LSPC_OFS_CTRL, 32'h0, q);
        settle();
        chk("addr", 32'h13, host_reg_addr);
        chk("valid", 32'h1, host_addr_valid);
        chk("toff_par", 32'h0, rx_term_disable);
        chk("mon_par", 32'h0, monitor_active);
        host_mode <= 2'h1;
        settle();
        xfer(1'b1, `LSPC_OFS_CTRL, 32'h1, q);
        settle();
        chk("addr_ser", 32'h0, host_reg_addr);
        chk("valid_ser", 32'h0, host_addr_valid);
    endtask : t_parallel

    // Status and route readback, then the sticky pin violation in multiplexed mode
    task automatic t_status;
        xfer(1'b1, `LSPC_OFS_CTRL, 32'h3, q);
        host_mode <= 2'h3;
        pin_req <= 5'h1a;
        settle();
        xfer(1'b0, `LSPC_OFS_ROUTE, 32'h0, q);
        chk("route", 32'h33, q);
        xfer(1'b0, `LSPC_OFS_STATUS, 32'h0, q);
        chk("stat_hw", 32'h1fa, q);
        xfer(1'b1, `LSPC_OFS_CTRL, 32'h2, q);
        settle();
        chk("valid_mux", 32'h0, host_addr_valid);
        xfer(1'b1, `LSPC_OFS_STATUS, 32'h200, q);
        xfer(1'b0, `LSPC_OFS_STATUS, 32'h0, q);
        chk("viol_set", 32'h2fa, q);
        host_mode <= 2'h2;
        settle();
        xfer(1'b1, `LSPC_OFS_STATUS, 32'h200, q);
        xfer(1'b0, `LSPC_OFS_STATUS, 32'h0, q);
        chk("viol_clr", 32'h0e0, q);
    endtask : t_status

    // Main sequence
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_monitor();
        t_oe();
        t_edge();
        t_parallel();
        t_status();
        close_out();
    end

    // Watchdog against a hung bus
    initial
    begin
        #50us;
        errors++;
        close_out();
    end
endmodule : tb_lspc_pin_control
